// [core/msx_defines.vh]
// msx_defines.vh: offsets, fields, reset values and encodings for the
// miscellaneous system instruction unit.
// assumes: included by bare name from core/ design files.
`ifndef MSX_DEFINES_VH
`define MSX_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// apb register map (byte addresses)
`define MSX_CTRL_OFFSET 12'h000
`define MSX_STATUS_OFFSET 12'h004
`define MSX_CTRL_RESET 32'h00000000

// control fields
`define MSX_CTRL_LOCKUP_BIT 0

// status fields
`define MSX_ST_HALTED_BIT 0
`define MSX_ST_LOCKUP_BIT 1
`define MSX_ST_IMASK_BIT 2
`define MSX_ST_EVENT_BIT 3
`define MSX_ST_SYNCWAIT_BIT 4
`define MSX_ST_SPSEL_BIT 5
`define MSX_ST_FLAGS_LSB 28

////////////////////////////////////////////////////////////////////////
// reset values of the special registers
`define MSX_FLAGS_RESET 4'h0
`define MSX_SP_RESET 32'h00000000
`define MSX_IMASK_RESET 1'b0
`define MSX_SPSEL_RESET 1'b0

////////////////////////////////////////////////////////////////////////
// instruction encodings (first halfword in the upper half for 32-bit)
`define MSX_OP_BREAK 8'hBE
`define MSX_OP_SERVICE 8'hDF
`define MSX_OP_MASK_SET 16'hB672
`define MSX_OP_MASK_CLR 16'hB662
`define MSX_OP_NOOP 16'hBF00
`define MSX_OP_SENDEV 16'hBF40
`define MSX_OP_BAR_HI 16'hF3BF
`define MSX_OP_SYNC_LO 12'h8F4
`define MSX_OP_ORDER_LO 12'h8F5
`define MSX_OP_IFLUSH_LO 12'h8F6
`define MSX_OP_S2G_HI 16'hF3EF
`define MSX_OP_S2G_TAG 4'h8
`define MSX_OP_G2S_HI 12'hF38
`define MSX_OP_G2S_TAG 8'h88

////////////////////////////////////////////////////////////////////////
// special register selectors
`define MSX_SEL_APP 8'h00
`define MSX_SEL_APP_EXC 8'h01
`define MSX_SEL_APP_EXE 8'h02
`define MSX_SEL_ALL 8'h03
`define MSX_SEL_EXC 8'h05
`define MSX_SEL_EXE 8'h06
`define MSX_SEL_EXC_EXE 8'h07
`define MSX_SEL_MAIN_SP 8'h08
`define MSX_SEL_PROC_SP 8'h09
`define MSX_SEL_IMASK 8'h10
`define MSX_SEL_CONTROL 8'h14

`endif

// [core/msx_sync.v]
// msx_sync: two flip-flop synchroniser for asynchronous level inputs.
// assumes: each bit is an independent level; no bus coherency implied.
module msx_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // levels
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

reg [WIDTH-1:0] meta;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        meta <= {WIDTH{1'b0}};
        dout <= {WIDTH{1'b0}};
    end
    else
    begin
        meta <= din;
        dout <= meta;
    end
end

endmodule // msx_sync

// [core/msx_exec.v]
// msx_exec: execute unit for the miscellaneous system instructions,
// holding flags, interrupt mask, stack pointers and the event register.
// assumes: one instruction offered per cycle on pclk; debugger and
// event pins are asynchronous; mem_idle comes from pclk logic.
`include "msx_defines.vh"

////////////////////////////////////////////////////////////////////////
// Operation
// [RULE1] breakpoint halts core when debugger attached
// [RULE2] breakpoint immediate ignored by execution
// [RULE3] no debugger: breakpoint faults or locks up
// [RULE4] mask-set instruction sets interrupt mask bit
// [RULE5] mask-clear instruction clears interrupt mask bit
// [RULE6] mask changes leave condition flags alone
// [RULE7] order barrier orders earlier before later accesses
// [RULE8] order barrier never stalls non-memory instructions
// [RULE9] nothing executes past sync barrier until done
// [RULE10] sync barrier completes once accesses finished
// [RULE11] instruction barrier flushes pipeline for refetch
// [RULE12] special-to-general move copies selected register
// [RULE13] software never targets stack or program counter
// [RULE14] general-to-special move writes selected register
// [RULE15] software never sources stack or program counter
// [RULE16] status view writes take flags from operand
// [RULE17] no-operation does nothing, takes no time
// [RULE18] software pads with no-operation, not delay
// [RULE19] send-event broadcasts event to all processors
// [RULE20] send-event sets local event register
// [RULE21] service call raises service call exception
// [RULE22] service call immediate ignored by execution
// [RULE23] other instructions here keep flags unaltered
// [RULE24] unknown selectors read zero, ignore writes
module msx_exec (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // instruction issue
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire instr_is32,
    input wire [31:0] src_value,
    output reg instr_ready,
    // register file write-back
    output reg rd_we,
    output reg [3:0] rd_addr,
    output reg [31:0] rd_data,
    // special register state
    output reg [3:0] cond_flags,
    output reg interrupt_mask_bit,
    output reg [31:0] main_stack_pointer,
    output reg [31:0] process_stack_pointer,
    output reg stack_select,
    // exception logic
    input wire [5:0] exc_number,
    output reg service_call_req,
    output reg fault_req,
    // memory system
    input wire mem_idle,
    output reg order_fence,
    output reg pipe_flush,
    // debugger
    input wire debug_attached_pin,
    input wire debug_resume_pin,
    output reg debug_halted,
    output reg core_lockup,
    // events
    input wire event_in_pin,
    input wire event_clear,
    output reg event_out,
    output reg event_reg
);

localparam ST_RUN = 2'd0;
localparam ST_SYNC = 2'd1;
localparam ST_FLUSH = 2'd2;
localparam ST_HALT = 2'd3;

////////////////////////////////////////////////////////////////////////
// selector classification

function sel_has_flags;
    input [7:0] sel;
    begin
        sel_has_flags = (sel == `MSX_SEL_APP) ||
            (sel == `MSX_SEL_APP_EXC) || (sel == `MSX_SEL_APP_EXE) ||
            (sel == `MSX_SEL_ALL);
    end
endfunction

function sel_has_exc;
    input [7:0] sel;
    begin
        sel_has_exc = (sel == `MSX_SEL_APP_EXC) ||
            (sel == `MSX_SEL_ALL) || (sel == `MSX_SEL_EXC) ||
            (sel == `MSX_SEL_EXC_EXE);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge detection

wire [2:0] pins_sync;
reg resume_d;
reg event_in_d;
reg [1:0] state;
reg [1:0] next_state;
reg next_lockup;
reg ctrl_lockup;

msx_sync #(
    .WIDTH(3)
) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({event_in_pin, debug_resume_pin, debug_attached_pin}),
    .dout(pins_sync)
);

wire dbg_attached = pins_sync[0];
wire resume_edge = pins_sync[1] & ~resume_d;
wire event_edge = pins_sync[2] & ~event_in_d;

////////////////////////////////////////////////////////////////////////
// decode

wire take = instr_valid & instr_ready;
wire [15:0] hw_a = instr_is32 ? instr_word[31:16] : instr_word[15:0];
wire [15:0] hw_b = instr_word[15:0];
wire t16 = take & ~instr_is32;
wire t32 = take & instr_is32;
wire [7:0] sel = hw_b[7:0];

// [RULE2] immediate byte masked out
wire dec_break = t16 & (hw_a[15:8] == `MSX_OP_BREAK);
// [RULE22] immediate byte masked out
wire dec_service = t16 & (hw_a[15:8] == `MSX_OP_SERVICE);
wire dec_mask_set = t16 & (hw_a == `MSX_OP_MASK_SET);
wire dec_mask_clr = t16 & (hw_a == `MSX_OP_MASK_CLR);
wire dec_sendev = t16 & (hw_a == `MSX_OP_SENDEV);
wire dec_bar = t32 & (hw_a == `MSX_OP_BAR_HI);
wire dec_sync = dec_bar & (hw_b[15:4] == `MSX_OP_SYNC_LO);
wire dec_order = dec_bar & (hw_b[15:4] == `MSX_OP_ORDER_LO);
wire dec_iflush = dec_bar & (hw_b[15:4] == `MSX_OP_IFLUSH_LO);
wire dec_s2g = t32 & (hw_a == `MSX_OP_S2G_HI) &
    (hw_b[15:12] == `MSX_OP_S2G_TAG);
wire dec_g2s = t32 & (hw_a[15:4] == `MSX_OP_G2S_HI) &
    (hw_b[15:8] == `MSX_OP_G2S_TAG);
// [RULE17] no-operation retires with no effect
// anything not decoded above, no-operation included, just retires

////////////////////////////////////////////////////////////////////////
// special register read mux

reg [31:0] spec_rd;

// [RULE12] selected source onto write-back
always @*
begin
    spec_rd = 32'h00000000;
    if (sel_has_flags(sel))
        spec_rd[31:28] = cond_flags;
    if (sel_has_exc(sel))
        spec_rd[5:0] = exc_number;
    case (sel)
        `MSX_SEL_MAIN_SP: spec_rd = main_stack_pointer;
        `MSX_SEL_PROC_SP: spec_rd = process_stack_pointer;
        `MSX_SEL_IMASK: spec_rd[0] = interrupt_mask_bit;
        `MSX_SEL_CONTROL: spec_rd[1] = stack_select;
        // [RULE24] reserved selectors read zero
        default: spec_rd = spec_rd;
    endcase
end

////////////////////////////////////////////////////////////////////////
// sequencing: barrier stalls, flush, halt and lockup

always @*
begin
    next_state = state;
    next_lockup = core_lockup;
    case (state)
        ST_RUN:
        begin
            // [RULE9] stall issue behind sync barrier
            if (dec_sync)
                next_state = ST_SYNC;
            // [RULE11] one dead cycle while fetch restarts
            else if (dec_iflush)
                next_state = ST_FLUSH;
            // [RULE1] enter halted debug state
            else if (dec_break & dbg_attached)
                next_state = ST_HALT;
            // [RULE3] lockup when no debugger
            else if (dec_break & ctrl_lockup)
                next_lockup = 1'b1;
        end
        // [RULE10] complete once memory drained
        ST_SYNC:
            if (mem_idle)
                next_state = ST_RUN;
        ST_FLUSH:
            next_state = ST_RUN;
        ST_HALT:
            if (resume_edge)
                next_state = ST_RUN;
        default:
            next_state = ST_RUN;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_RUN;
        core_lockup <= 1'b0;
        instr_ready <= 1'b0;
        debug_halted <= 1'b0;
        resume_d <= 1'b0;
        event_in_d <= 1'b0;
    end
    else
    begin
        state <= next_state;
        // lockup is left only through reset
        core_lockup <= next_lockup;
        instr_ready <= (next_state == ST_RUN) & ~next_lockup;
        debug_halted <= (next_state == ST_HALT);
        resume_d <= pins_sync[1];
        event_in_d <= pins_sync[2];
    end
end

////////////////////////////////////////////////////////////////////////
// one-cycle requests to memory, exceptions and other processors

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        order_fence <= 1'b0;
        pipe_flush <= 1'b0;
        service_call_req <= 1'b0;
        fault_req <= 1'b0;
        event_out <= 1'b0;
    end
    else
    begin
        // [RULE7] fence marker to the memory system
        // [RULE8] fence only, issue never stalls
        order_fence <= dec_order;
        // [RULE11] refetch request after barrier
        pipe_flush <= dec_iflush;
        // [RULE21] raise service call exception
        service_call_req <= dec_service;
        // [RULE3] fault when no debugger and no lockup
        fault_req <= dec_break & ~dbg_attached & ~ctrl_lockup;
        // [RULE19] broadcast to all processors
        event_out <= dec_sendev;
    end
end

// [RULE20] local event register, set beats clear
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        event_reg <= 1'b0;
    else if (dec_sendev | event_edge)
        event_reg <= 1'b1;
    else if (event_clear)
        event_reg <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// special registers and write-back

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cond_flags <= `MSX_FLAGS_RESET;
        interrupt_mask_bit <= `MSX_IMASK_RESET;
        main_stack_pointer <= `MSX_SP_RESET;
        process_stack_pointer <= `MSX_SP_RESET;
        stack_select <= `MSX_SPSEL_RESET;
        rd_we <= 1'b0;
        rd_addr <= 4'h0;
        rd_data <= 32'h00000000;
    end
    else
    begin
        rd_we <= dec_s2g;
        if (dec_s2g)
        begin
            rd_addr <= hw_b[11:8];
            rd_data <= spec_rd;
        end
        // [RULE4] mask set blocks configurable interrupts
        if (dec_mask_set)
            interrupt_mask_bit <= 1'b1;
        // [RULE5] mask clear re-enables interrupts
        else if (dec_mask_clr)
            interrupt_mask_bit <= 1'b0;
        // [RULE6] flags only written by status moves
        // [RULE23] all other instructions keep flags
        if (dec_g2s)
        begin
            // [RULE16] flags straight from operand
            if (sel_has_flags(sel))
                cond_flags <= src_value[31:28];
            // [RULE14] write selected special register
            case (sel)
                `MSX_SEL_MAIN_SP:
                    main_stack_pointer <= {src_value[31:2], 2'b00};
                `MSX_SEL_PROC_SP:
                    process_stack_pointer <= {src_value[31:2], 2'b00};
                `MSX_SEL_IMASK:
                    interrupt_mask_bit <= src_value[0];
                `MSX_SEL_CONTROL:
                    // stack choice is fixed while handling an exception
                    if (exc_number == 6'h00)
                        stack_select <= src_value[1];
                // [RULE24] reserved selectors ignore writes
                default:
                    stack_select <= stack_select;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// apb slave: one wait state, so prdata and pready are both registered

wire apb_access = psel & penable;
wire apb_done = apb_access & pready;
wire hit_ctrl = (paddr == `MSX_CTRL_OFFSET);
wire hit_status = (paddr == `MSX_STATUS_OFFSET);
reg [31:0] status_word;

always @*
begin
    status_word = 32'h00000000;
    status_word[`MSX_ST_HALTED_BIT] = debug_halted;
    status_word[`MSX_ST_LOCKUP_BIT] = core_lockup;
    status_word[`MSX_ST_IMASK_BIT] = interrupt_mask_bit;
    status_word[`MSX_ST_EVENT_BIT] = event_reg;
    status_word[`MSX_ST_SYNCWAIT_BIT] = (state == ST_SYNC);
    status_word[`MSX_ST_SPSEL_BIT] = stack_select;
    status_word[`MSX_ST_FLAGS_LSB+3:`MSX_ST_FLAGS_LSB] = cond_flags;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
        ctrl_lockup <= 1'b0;
    end
    else
    begin
        pready <= apb_access & ~pready;
        if (apb_access & ~pready)
        begin
            pslverr <= ~(hit_ctrl | (hit_status & ~pwrite));
            if (pwrite | ~hit_ctrl & ~hit_status)
                prdata <= 32'h00000000;
            else if (hit_ctrl)
                prdata <= {31'h00000000, ctrl_lockup};
            else
                prdata <= status_word;
        end
        else if (apb_done)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        if (apb_done & pwrite & hit_ctrl)
            ctrl_lockup <= pwdata[`MSX_CTRL_LOCKUP_BIT];
    end
end

endmodule // msx_exec

// [sim/msx_checker.sv]
// msx_checker: concurrent checks on the execute unit's issue side.
// assumes: bound to msx_exec; one clock pclk, async reset presetn.
module msx_checker (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // instruction issue
    input wire instr_valid,
    input wire [31:0] instr_word,
    input wire instr_is32,
    input wire instr_ready,
    // results
    input wire rd_we,
    input wire [3:0] rd_addr,
    input wire [3:0] cond_flags,
    input wire interrupt_mask_bit,
    input wire service_call_req,
    input wire mem_idle,
    input wire order_fence,
    input wire pipe_flush,
    input wire event_out,
    input wire event_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    wire t16 = instr_valid && instr_ready && !instr_is32;
    wire t32 = instr_valid && instr_ready && instr_is32;
    wire [15:0] lo = instr_word[15:0];
    wire [27:0] bar = instr_word[31:4];

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////
    chk_mask_set: assert property (
        t16 && lo == 16'hB672 |=> interrupt_mask_bit)
        else $error("mask set not seen");
    chk_mask_clear: assert property (
        t16 && lo == 16'hB662 |=> !interrupt_mask_bit)
        else $error("mask clear not seen");
    chk_mask_flags: assert property (
        t16 && (lo == 16'hB672 || lo == 16'hB662) |=> $stable(cond_flags))
        else $error("flags moved on mask change");
    chk_quiet_ops: assert property (
        t16 && (lo == 16'hBF00 || lo == 16'hBF40)
        |=> $stable(cond_flags) && !rd_we)
        else $error("quiet op changed state");
    chk_event_send: assert property (
        t16 && lo == 16'hBF40 |=> event_out && event_reg)
        else $error("event not sent");
    chk_service_req: assert property (
        t16 && lo[15:8] == 8'hDF |=> service_call_req)
        else $error("service call not raised");
    chk_order_fence: assert property (
        t32 && bar == 28'hF3BF8F5 |=> order_fence && instr_ready)
        else $error("order barrier wrong");
    chk_sync_stall: assert property (
        t32 && bar == 28'hF3BF8F4 |=> !instr_ready)
        else $error("sync barrier did not stall");
    // ready may not return while accesses are still outstanding
    chk_sync_wait: assert property (
        t32 && bar == 28'hF3BF8F4 ##1 !mem_idle [*3] |=> !instr_ready)
        else $error("sync barrier ended early");
    chk_flush_once: assert property (
        t32 && bar == 28'hF3BF8F6 |=> pipe_flush && !instr_ready ##1 instr_ready)
        else $error("flush cycle wrong");
    chk_move_wback: assert property (
        t32 && instr_word[31:16] == 16'hF3EF
        |=> rd_we && rd_addr == $past(instr_word[11:8]))
        else $error("special move write-back wrong");

    cover property (t32 && bar == 28'hF3BF8F4 ##1 !mem_idle);
    cover property (t16 && lo[15:8] == 8'hBE);
    cover property (t32 && instr_word[31:16] == 16'hF3EF);
endmodule // msx_checker

// [sim/msx_far_model.sv]
// msx_far_model: memory system and debugger seen from the core.
// assumes: bench pulses the kick inputs for one pclk cycle.
module msx_far_model #(
    parameter MEM_BUSY = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // bench controls
    input wire mem_kick,
    input wire dbg_on,
    input wire resume_kick,
    // toward the core
    output logic mem_idle,
    output logic debug_attached_pin,
    output logic debug_resume_pin,
    output logic [5:0] exc_number
);
    timeunit 1ns;
    timeprecision 1ps;
    int busy;
    int rsm;

    // outstanding accesses keep the memory side busy for a while
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 0;
            rsm <= 0;
        end
        else
        begin
            busy <= mem_kick ? MEM_BUSY : (busy > 0 ? busy - 1 : 0);
            rsm <= resume_kick ? 4 : (rsm > 0 ? rsm - 1 : 0);
        end
    end
    assign mem_idle = (busy == 0);
    assign debug_resume_pin = (rsm > 0);
    assign debug_attached_pin = dbg_on;
    assign exc_number = 6'h00;
endmodule // msx_far_model

// [sim/testbench.sv]
// testbench: drives APB and the instruction issue port of msx_exec.
// assumes: far model stands for memory, debugger and exceptions.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, instr_word, src_value, rd_data, d;
    logic [31:0] main_stack_pointer, process_stack_pointer;
    logic instr_valid, instr_is32, instr_ready, rd_we, e;
    logic [3:0] rd_addr, cond_flags;
    logic [5:0] exc_number;
    logic interrupt_mask_bit, stack_select, service_call_req, fault_req;
    logic mem_idle, order_fence, pipe_flush, debug_attached_pin;
    logic debug_resume_pin, debug_halted, core_lockup, event_in_pin;
    logic event_clear, event_out, event_reg, mem_kick, dbg_on, resume_kick;
    int miscompares = 0;
    int checked = 0;

    msx_exec u_msx_exec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word,
        .instr_is32, .src_value, .instr_ready, .rd_we, .rd_addr, .rd_data,
        .cond_flags, .interrupt_mask_bit, .main_stack_pointer,
        .process_stack_pointer, .stack_select, .exc_number,
        .service_call_req, .fault_req, .mem_idle, .order_fence, .pipe_flush,
        .debug_attached_pin, .debug_resume_pin, .debug_halted, .core_lockup,
        .event_in_pin, .event_clear, .event_out, .event_reg);
    msx_far_model #(.MEM_BUSY(8)) u_msx_far_model (.pclk, .presetn,
        .mem_kick, .dbg_on, .resume_kick, .mem_idle, .debug_attached_pin,
        .debug_resume_pin, .exc_number);

    initial
    begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task expired;
        chk(32'h0, 32'h1);
        wrap_up;
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        d = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) expired;
    endtask

    // outputs of a taken instruction are sampled just after the take edge
    task iss(input logic [31:0] w, input logic wide, input logic [31:0] s);
        int n;
        @(posedge pclk);
        instr_valid <= 1;
        instr_word <= w;
        instr_is32 <= wide;
        src_value <= s;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (instr_ready !== 1'b1 && n < 40);
        instr_valid <= 0;
        if (n >= 40) expired;
        #1;
    endtask

    task kick(input int which);
        @(posedge pclk);
        if (which == 0) mem_kick <= 1;
        else resume_kick <= 1;
        @(posedge pclk);
        mem_kick <= 0;
        resume_kick <= 0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, instr_valid, instr_is32} = 5'h00;
        {paddr, pwdata, instr_word, src_value} = 108'h0;
        {event_in_pin, event_clear, mem_kick, dbg_on, resume_kick} = 5'h00;
        presetn = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        apb(0, 12'h004, 0);
        chk(d, 32'h0);
        apb(1, 12'h000, 32'h1);
        apb(0, 12'h000, 0);
        chk(d, 32'h1);
        apb(1, 12'h000, 32'h0);
        apb(0, 12'h010, 0);
        chk({31'h0, e}, 32'h1);
        apb(1, 12'h004, 32'hFFFFFFFF);
        chk({31'h0, e}, 32'h1);
        $display("test registers done");
        iss(32'hF3808800, 1, 32'hA0000000);
        chk(cond_flags, 4'hA);
        iss(32'hF3808808, 1, 32'h1234567B);
        chk(main_stack_pointer, 32'h12345678);
        iss(32'hF3808809, 1, 32'h8765432F);
        chk(process_stack_pointer, 32'h8765432C);
        iss(32'hF3808814, 1, 32'h00000002);
        chk(stack_select, 1'b1);
        iss(32'h0000B672, 0, 0);
        chk(interrupt_mask_bit, 1'b1);
        chk(cond_flags, 4'hA);
        iss(32'hF3EF8310, 1, 0);
        chk({rd_we, rd_addr}, 5'h13);
        chk(rd_data, 32'h1);
        iss(32'hF3EF8533, 1, 0);
        chk(rd_we, 1'b1);
        chk(rd_data, 32'h0);
        iss(32'h0000B662, 0, 0);
        chk(interrupt_mask_bit, 1'b0);
        $display("test moves done");
        iss(32'h0000BF40, 0, 0);
        chk({event_out, event_reg}, 2'h3);
        for (int i = 0; i < 256; i += 255)
        begin
            iss({24'h0000DF, i[7:0]}, 0, 0);
            chk({service_call_req, cond_flags}, 5'h1A);
        end
        iss(32'h0000BF00, 0, 0);
        chk(cond_flags, 4'hA);
        @(posedge pclk);
        event_clear <= 1;
        @(posedge pclk);
        event_clear <= 0;
        #1 chk(event_reg, 1'b0);
        // a rising event pin sets the register after synchronising
        event_in_pin <= 1;
        repeat (4) @(posedge pclk);
        #1 chk(event_reg, 1'b1);
        @(posedge pclk);
        event_clear <= 1;
        @(posedge pclk);
        event_clear <= 0;
        #1 chk(event_reg, 1'b0);
        $display("test events done");
        iss(32'hF3BF8F5F, 1, 0);
        chk({order_fence, instr_ready}, 2'h3);
        kick(0);
        iss(32'hF3BF8F4F, 1, 0);
        repeat (3) @(posedge pclk);
        #1 chk(instr_ready, 1'b0);
        iss(32'hF3BF8F6F, 1, 0);
        chk({pipe_flush, instr_ready}, 2'h2);
        $display("test barriers done");
        iss(32'h0000BE00, 0, 0);
        chk({fault_req, core_lockup}, 2'h2);
        dbg_on <= 1;
        repeat (4) @(posedge pclk);
        iss(32'h0000BEFF, 0, 0);
        chk({debug_halted, cond_flags}, 5'h1A);
        kick(1);
        iss(32'h0000BF00, 0, 0);
        chk(debug_halted, 1'b0);
        dbg_on <= 0;
        apb(1, 12'h000, 32'h1);
        repeat (4) @(posedge pclk);
        iss(32'h0000BE10, 0, 0);
        chk(core_lockup, 1'b1);
        apb(0, 12'h004, 0);
        chk(d, 32'hA0000022);
        $display("test breakpoint done");
        wrap_up;
    end
endmodule // testbench

bind msx_exec msx_checker u_msx_checker (.pclk, .presetn, .instr_valid,
    .instr_word, .instr_is32, .instr_ready, .rd_we, .rd_addr, .cond_flags,
    .interrupt_mask_bit, .service_call_req, .mem_idle, .order_fence,
    .pipe_flush, .event_out, .event_reg);
